// ===== pkg/tflag_pkg.sv
// tflag_pkg: register map, field layout and reset values of the timer flag/status block
// assumes: 32-bit word registers on an ahb-lite slave, one clock domain
package tflag_pkg;
  localparam int unsigned num_channels = 6;
  // register byte addresses
  localparam logic [7:0] off_irq_enable_clear = 8'h24;
  localparam logic [7:0] off_irq_enable_set = 8'h28;
  localparam logic [7:0] off_event_flags = 8'h2c;
  localparam logic [7:0] off_unit_status = 8'h30;
  localparam logic [7:0] off_control = 8'h44;
  localparam logic [7:0] off_channel_value0 = 8'h48;
  // event_flags / enable field positions
  localparam int unsigned pos_overflow = 0;
  localparam int unsigned pos_retrigger = 1;
  localparam int unsigned pos_counter = 2;
  localparam int unsigned pos_error = 3;
  localparam int unsigned pos_update_fault = 10;
  localparam int unsigned pos_debug_fault = 11;
  localparam int unsigned pos_soft_fault_a = 12;
  localparam int unsigned pos_soft_fault_b = 13;
  localparam int unsigned pos_hard_fault_zero = 14;
  localparam int unsigned pos_hard_fault_one = 15;
  localparam int unsigned pos_channel = 16;
  localparam logic [31:0] flag_mask = 32'h003f_fc0f;
  // unit_status field positions
  localparam int unsigned st_stop = 0;
  localparam int unsigned st_index = 1;
  localparam int unsigned st_update_fault = 2;
  localparam int unsigned st_debug_fault = 3;
  localparam int unsigned st_fault_in = 8;
  localparam int unsigned st_soft_fault_a = 12;
  localparam int unsigned st_soft_fault_b = 13;
  localparam int unsigned st_hard_fault_zero = 14;
  localparam int unsigned st_hard_fault_one = 15;
  localparam int unsigned st_buffer_valid = 16;
  localparam int unsigned st_compare = 24;
  localparam logic [31:0] status_reset = 32'h0000_0001;
  // control register fields
  localparam int unsigned ctl_lock_update = 0;
  localparam int unsigned ctl_capture = 8;
  localparam int unsigned ctl_halt_b = 16;
  // ahb codes
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
endpackage

// ===== pkg/tflag_bus_if.sv
// tflag_bus_if: decoded register access passed from the bus slave to the flag core
// assumes: one clock; strobes are one-cycle pulses in the ahb data phase
`timescale 1ns/1ps
`default_nettype none
interface tflag_bus_if;
  logic wr; // write strobe
  logic rd; // read strobe
  logic full_word; // write was a whole word
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr, output rd, output full_word, output addr, output wdata,
    input rdata);
  modport core (input wr, input rd, input full_word, input addr, input wdata,
    output rdata);
endinterface
`default_nettype wire

// ===== rtl/tflag_ahb_slave.sv
// tflag_ahb_slave: ahb-lite slave front end, zero wait states, always okay
// assumes: one master, clock enable freezes the bus state as well
`timescale 1ns/1ps
`default_nettype none
module tflag_ahb_slave (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // decoded access
  tflag_bus_if.slave bus
);
  import tflag_pkg::*;
  logic ph_wr;
  logic ph_rd;
  logic ph_full;
  logic [7:0] ph_addr;

  // capture the address phase
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_full <= 1'b0;
      ph_addr <= 8'h00;
    end else if (ce && hready) begin
      ph_wr <= hsel && htrans[1] && hwrite;
      ph_rd <= hsel && htrans[1] && !hwrite;
      ph_full <= hsize == hsize_word;
      ph_addr <= haddr[7:0];
    end
  end

  // data phase strobes
  assign bus.wr = ph_wr && ce;
  assign bus.rd = ph_rd && ce;
  assign bus.full_word = ph_full;
  assign bus.addr = ph_addr;
  assign bus.wdata = hwdata;
endmodule // tflag_ahb_slave
`default_nettype wire

// ===== rtl/tflag_core.sv
// tflag_core: interrupt enables, event flags and unit status of a control timer
// assumes: events are one-cycle pulses from logic on clk; fault pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - writing one to a channel enable-set bit enables it; zero leaves it.
// - enable-set ones turn on fault, debug, update, error, counter, retrigger, overflow.
// - channel flag rises the cycle after a match or a valid capture.
// - writing one to a channel flag clears it; zero leaves it.
// - in capture mode reading the channel value clears its flag.
// - hard fault one flag rises three cycles after the fault pin; write one clears.
// - hard fault zero flag clears on write one; zero has no effect.
// - soft fault a and b flags rise after their fault; write one clears.
// - debug fault flag rises after debug fault entry; write one clears.
// - update fault flag rises on index change under lock update; write one clears.
// - error flag rises on capture while channel flag still set; write one clears.
// - counter flag rises after a counter event; write one clears.
// - retrigger flag rises after a retrigger; write one clears.
// - overflow flag rises after overflow; write one clears, zero ignored.
// - compare status bits read the live compare output levels.
// - compare buffer-valid sets on buffer write, clears on update or locked write one.
// - capture buffer-valid sets on capture, clears when channel value is read.
// - hard fault state sets once the synchronised input is high; write one clears only if input low.
// - counter resumes from last count after fault state clears; restart is software's.
// - soft fault b state set by fault, cleared by resume or write one if input low.
// - fault input status bits follow the fault inputs after the two-stage synchroniser.
// - enable set and clear views share one enable register.
module tflag_core (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // counter datapath events
  input wire logic [5:0] channel_match_capture,
  input wire logic [5:0] buffer_write,
  input wire logic update_event,
  input wire logic counter_event,
  input wire logic retrigger_event,
  input wire logic overflow_event,
  input wire logic index_change,
  input wire logic debug_fault_entry,
  input wire logic soft_fault_a_resume,
  input wire logic soft_fault_b_resume,
  input wire logic counter_stopped,
  input wire logic ramp_index,
  input wire logic [5:0] compare_output_level,
  input wire logic [31:0] capture_value,
  // fault pins, asynchronous
  input wire logic hard_fault_one_pin,
  input wire logic hard_fault_zero_pin,
  input wire logic soft_fault_b_pin,
  input wire logic soft_fault_a_pin,
  // outputs to the counter and the cpu
  output logic irq,
  output logic counter_release,
  output logic [3:0] fault_halt
);
  import tflag_pkg::*;
  tflag_bus_if bus ();
  logic [31:0] irq_enable;
  logic [31:0] event_flags;
  logic [5:0] channel_buffer_valid;
  logic hard_fault_one;
  logic hard_fault_zero;
  logic soft_fault_a;
  logic soft_fault_b;
  logic debug_fault_state;
  logic update_fault_state;
  logic [3:0] fault_meta;
  logic [3:0] fault_in;
  logic [3:0] fault_in_q;
  logic [31:0] control;
  logic [31:0] channel_value [0:5];
  logic [31:0] next_rdata;
  logic rd_accept;
  logic [7:0] rd_addr;
  logic [31:0] wone;
  logic [31:0] stone;
  logic [5:0] value_read;
  logic [5:0] is_capture;
  logic lock_update;

  tflag_ahb_slave u_slave (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .bus(bus)
  );

  // write-one masks decoded once
  function automatic logic [31:0] ones_at(input logic [7:0] off);
    ones_at = (bus.wr && bus.addr == off) ? bus.wdata : 32'h0000_0000;
  endfunction

  // channel value word address, shared by the read strobes and the read mux
  function automatic logic [7:0] value_addr(input int idx);
    value_addr = off_channel_value0 + 8'(4 * idx);
  endfunction

  assign wone = ones_at(off_event_flags) & flag_mask;
  assign stone = bus.full_word ? ones_at(off_unit_status) : 32'h0000_0000;
  assign lock_update = control[ctl_lock_update];
  assign is_capture = control[ctl_capture +: 6];

  // a read is answered from its address phase so that hrdata stands in the data phase
  assign rd_accept = ce && hready && hsel && htrans[1] && !hwrite;
  assign rd_addr = haddr[7:0];

  // channel value reads
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      value_read[i] = bus.rd && bus.addr == value_addr(i);
    end
  end

  // fault pin synchronisers, two stages before any use
  // fault_in_q only feeds the rising-edge detect of the fault flags
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_meta <= 4'h0;
      fault_in <= 4'h0;
      fault_in_q <= 4'h0;
    end else if (ce) begin
      fault_meta <= {hard_fault_one_pin, hard_fault_zero_pin, soft_fault_b_pin,
        soft_fault_a_pin};
      fault_in <= fault_meta;
      fault_in_q <= fault_in;
    end
  end

  // one shared enable register behind the set and clear views
  // ones written to the clear view drop enables; zero bits leave them alone
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_enable <= 32'h0000_0000;
    end else if (ce) begin
      if (bus.wr && bus.addr == off_irq_enable_set) begin
        irq_enable <= irq_enable | (bus.wdata & flag_mask);
      end else if (bus.wr && bus.addr == off_irq_enable_clear) begin
        irq_enable <= irq_enable & ~bus.wdata;
      end
    end
  end

  // event flags: clear by write one or capture read, hardware set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      event_flags <= 32'h0000_0000;
    end else if (ce) begin
      logic [31:0] set;
      logic [31:0] clr;
      set = 32'h0000_0000;
      clr = wone;
      for (int i = 0; i < 6; i++) begin
        set[pos_channel + i] = channel_match_capture[i];
        if (is_capture[i] && value_read[i]) begin
          clr[pos_channel + i] = 1'b1;
        end
        if (is_capture[i] && channel_match_capture[i] && event_flags[pos_channel + i]) begin
          set[pos_error] = 1'b1;
        end
      end
      set[pos_hard_fault_one] = fault_in[3] && !fault_in_q[3];
      set[pos_hard_fault_zero] = fault_in[2] && !fault_in_q[2];
      set[pos_soft_fault_b] = fault_in[1] && !fault_in_q[1];
      set[pos_soft_fault_a] = fault_in[0] && !fault_in_q[0];
      set[pos_debug_fault] = debug_fault_entry;
      set[pos_update_fault] = index_change && lock_update;
      set[pos_counter] = counter_event;
      set[pos_retrigger] = retrigger_event;
      set[pos_overflow] = overflow_event;
      event_flags <= ((event_flags & ~clr) | set) & flag_mask;
    end
  end

  // channel buffer valid bits
  // a capture beats a read of the value in the same cycle, so the valid bit stays set
  always_ff @(posedge clk) begin
    if (srst) begin
      channel_buffer_valid <= 6'h00;
    end else if (ce) begin
      for (int i = 0; i < 6; i++) begin
        if (is_capture[i]) begin
          if (channel_match_capture[i]) begin
            channel_buffer_valid[i] <= 1'b1;
          end else if (value_read[i]) begin
            channel_buffer_valid[i] <= 1'b0;
          end
        end else if (buffer_write[i]) begin
          channel_buffer_valid[i] <= 1'b1;
        end else if (update_event || (lock_update && stone[st_buffer_valid + i])) begin
          channel_buffer_valid[i] <= 1'b0;
        end
      end
    end
  end

  // fault state bits: hardware set wins over software clear
  // a software clear is refused while the synchronised input is still high
  always_ff @(posedge clk) begin
    if (srst) begin
      hard_fault_one <= 1'b0;
      hard_fault_zero <= 1'b0;
      soft_fault_a <= 1'b0;
      soft_fault_b <= 1'b0;
      debug_fault_state <= 1'b0;
      update_fault_state <= 1'b0;
    end else if (ce) begin
      if (fault_in[3]) begin
        hard_fault_one <= 1'b1;
      end else if (stone[st_hard_fault_one]) begin
        hard_fault_one <= 1'b0;
      end
      if (fault_in[2]) begin
        hard_fault_zero <= 1'b1;
      end else if (stone[st_hard_fault_zero]) begin
        hard_fault_zero <= 1'b0;
      end
      if (fault_in[1]) begin
        soft_fault_b <= 1'b1;
      end else if (soft_fault_b_resume || stone[st_soft_fault_b]) begin
        soft_fault_b <= 1'b0;
      end
      if (fault_in[0]) begin
        soft_fault_a <= 1'b1;
      end else if (soft_fault_a_resume || stone[st_soft_fault_a]) begin
        soft_fault_a <= 1'b0;
      end
      if (debug_fault_entry) begin
        debug_fault_state <= 1'b1;
      end else if (stone[st_debug_fault]) begin
        debug_fault_state <= 1'b0;
      end
      if (index_change && lock_update) begin
        update_fault_state <= 1'b1;
      end else if (stone[st_update_fault]) begin
        update_fault_state <= 1'b0;
      end
    end
  end

  // control register and captured channel values
  // a capture that meets a still-set flag is dropped; the error flag reports it
  always_ff @(posedge clk) begin
    if (srst) begin
      control <= 32'h0000_0000;
      for (int i = 0; i < 6; i++) begin
        channel_value[i] <= 32'h0000_0000;
      end
    end else if (ce) begin
      if (bus.wr && bus.addr == off_control) begin
        control <= bus.wdata;
      end
      for (int i = 0; i < 6; i++) begin
        if (is_capture[i] && channel_match_capture[i] && !event_flags[pos_channel + i]) begin
          channel_value[i] <= capture_value;
        end
      end
    end
  end

  // irq, release and halt outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
      counter_release <= 1'b0;
      fault_halt <= 4'h0;
    end else if (ce) begin
      irq <= |(event_flags & irq_enable);
      counter_release <= control[ctl_halt_b] && soft_fault_b && stone[st_soft_fault_b]
        && !fault_in[1];
      fault_halt <= {hard_fault_one, hard_fault_zero, soft_fault_b, soft_fault_a};
    end
  end

  // read mux, decoded from the address phase; a read right behind a write to the
  // same word still shows the old value, as that write lands at the same edge
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_addr == off_irq_enable_clear || rd_addr == off_irq_enable_set) begin
      next_rdata = irq_enable;
    end else if (rd_addr == off_event_flags) begin
      next_rdata = event_flags;
    end else if (rd_addr == off_unit_status) begin
      next_rdata[st_compare +: 6] = compare_output_level;
      next_rdata[st_buffer_valid +: 6] = channel_buffer_valid;
      next_rdata[st_hard_fault_one] = hard_fault_one;
      next_rdata[st_hard_fault_zero] = hard_fault_zero;
      next_rdata[st_soft_fault_b] = soft_fault_b;
      next_rdata[st_soft_fault_a] = soft_fault_a;
      next_rdata[st_fault_in +: 4] = fault_in;
      next_rdata[st_debug_fault] = debug_fault_state;
      next_rdata[st_update_fault] = update_fault_state;
      next_rdata[st_index] = ramp_index;
      next_rdata[st_stop] = counter_stopped;
    end else if (rd_addr == off_control) begin
      next_rdata = control;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (rd_addr == value_addr(i)) begin
          next_rdata = channel_value[i];
        end
      end
    end
  end

  // registered bus answer: zero wait states; hrdata is loaded at the edge that takes
  // the read address, so it stands through the data phase and until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      if (rd_accept) begin
        hrdata <= next_rdata;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // the front end reads nothing back; the word stays on the carrier for completeness
  assign bus.rdata = next_rdata;
endmodule // tflag_core
`default_nettype wire

// ===== verification/tflag_core_props.sv
// tflag_core_props: port-level checks of the timer flag and status block
// assumes: bound into tflag_core, one clock, ahb master issues single word and byte transfers
`timescale 1ns/1ps
`default_nettype none
module tflag_core_props import tflag_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // status sources
  input wire logic counter_stopped,
  input wire logic [5:0] compare_output_level,
  input wire logic hard_fault_one_pin,
  input wire logic hard_fault_zero_pin,
  input wire logic soft_fault_b_pin,
  input wire logic soft_fault_a_pin,
  // outputs
  input wire logic irq,
  input wire logic counter_release,
  input wire logic [3:0] fault_halt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // a read address phase accepted by the slave
  logic rd_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  AST_READY: assert property (hreadyout)
    else $error("slave inserted a wait state");
  AST_RESP: assert property (!hresp)
    else $error("slave answered with an error");
  AST_RST: assert property (disable iff (1'b0) srst |=> !irq && fault_halt == 4'h0)
    else $error("outputs not cleared by reset");
  AST_UNMAPPED: assert property (rd_take && haddr == 32'h4 |-> ##1 hrdata == 32'h0)
    else $error("unmapped read returned data");
  AST_STATUS_LIVE: assert property (rd_take && haddr[7:0] == off_unit_status |-> ##1
    hrdata[29:24] == $past(compare_output_level) && hrdata[0] == $past(counter_stopped))
    else $error("status does not show live levels");
  AST_HF1: assert property (hard_fault_one_pin [*5] |=> fault_halt[3])
    else $error("hard fault one state missing");
  AST_HF0: assert property (hard_fault_zero_pin [*5] |=> fault_halt[2])
    else $error("hard fault zero state missing");
  AST_SFB: assert property (soft_fault_b_pin [*5] |=> fault_halt[1])
    else $error("soft fault b state missing");
  AST_SFA: assert property (soft_fault_a_pin [*5] |=> fault_halt[0])
    else $error("soft fault a state missing");
  AST_RELEASE: assert property (counter_release |=> !counter_release)
    else $error("counter release longer than a pulse");
  // main scenarios reached
  cover property ($rose(irq));
  cover property (counter_release);
  cover property ($rose(fault_halt[3]));
  cover property (rd_take && haddr[7:0] == off_unit_status);
endmodule // tflag_core_props
bind tflag_core tflag_core_props props (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .counter_stopped(counter_stopped), .compare_output_level(compare_output_level),
  .hard_fault_one_pin(hard_fault_one_pin), .hard_fault_zero_pin(hard_fault_zero_pin),
  .soft_fault_b_pin(soft_fault_b_pin), .soft_fault_a_pin(soft_fault_a_pin), .irq(irq),
  .counter_release(counter_release), .fault_halt(fault_halt));
`default_nettype wire

// ===== verification/tb_top.sv
// tb_top: self-checking bench of the timer flag and status block
// assumes: bench is the only ahb master; events are driven as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tflag_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, hsel = 1'b1, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, capv = 32'h0, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = hsize_word;
  logic [5:0] mc = 6'h0, bw = 6'h0, cmp = 6'h0;
  logic upd = 0, cnte = 0, rtr = 0, ovf = 0, idx = 0, dbg = 0, ra = 0, rb = 0, stp = 1, ramp = 0;
  logic [3:0] pin = 4'h0; // {hf1, hf0, sfb, sfa}
  logic hreadyout, hresp, irq, counter_release;
  logic [31:0] hrdata;
  logic [3:0] fault_halt;
  int error_cnt = 0, cmp_count = 0, cyc = 0, rel_cnt = 0;
  // the single slave's ready is the bus ready
  assign hready = hreadyout;
  always #12.5 clk = ~clk;
  tflag_core dut (.clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .channel_match_capture(mc), .buffer_write(bw),
    .update_event(upd), .counter_event(cnte), .retrigger_event(rtr), .overflow_event(ovf),
    .index_change(idx), .debug_fault_entry(dbg), .soft_fault_a_resume(ra),
    .soft_fault_b_resume(rb), .counter_stopped(stp), .ramp_index(ramp),
    .compare_output_level(cmp), .capture_value(capv), .hard_fault_one_pin(pin[3]),
    .hard_fault_zero_pin(pin[2]), .soft_fault_b_pin(pin[1]), .soft_fault_a_pin(pin[0]),
    .irq(irq), .counter_release(counter_release), .fault_halt(fault_halt));
  // release pulses and the hang limit
  always @(posedge clk) begin
    cyc++;
    if (counter_release === 1'b1) rel_cnt++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error %0t: run timed out", $time);
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one single transfer; read data is taken at the edge that ends the data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [2:0] sz);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    htrans <= htrans_nonseq;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, hsize_word);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp,
      input string m);
    bus(a, 1'b0, 32'h0, hsize_word);
    chk(q & msk, exp, m);
  endtask
  // reset values, live status levels, unmapped place
  task automatic t_reset();
    rdchk(off_event_flags, 32'hffff_ffff, 32'h0, "flags reset");
    rdchk(off_unit_status, 32'hffff_ffff, status_reset, "status reset");
    rdchk(off_irq_enable_set, 32'hffff_ffff, 32'h0, "enable reset");
    cmp <= 6'h2a; ramp <= 1'b1;
    rdchk(off_unit_status, 32'h3f00_0003, 32'h2a00_0003, "live levels");
    wr(8'h04, 32'hffff_ffff);
    rdchk(8'h04, 32'hffff_ffff, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  // enable set and clear views
  task automatic t_enable();
    wr(off_irq_enable_set, 32'h0001_0001);
    rdchk(off_irq_enable_clear, 32'hffff_ffff, 32'h0001_0001, "set one");
    wr(off_irq_enable_set, 32'h0);
    rdchk(off_irq_enable_set, 32'hffff_ffff, 32'h0001_0001, "set zero");
    wr(off_irq_enable_set, flag_mask);
    rdchk(off_irq_enable_set, 32'hffff_ffff, flag_mask, "set all");
    wr(off_irq_enable_clear, 32'h0020_0008);
    rdchk(off_irq_enable_set, 32'hffff_ffff, flag_mask & ~32'h0020_0008, "clear view");
    $display("test enable done");
  endtask
  // counter events, write one to clear, irq
  task automatic t_events();
    cnte <= 1; rtr <= 1; ovf <= 1;
    tick(1);
    cnte <= 0; rtr <= 0; ovf <= 0;
    rdchk(off_event_flags, 32'hffff_ffff, 32'h7, "event flags");
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(off_event_flags, 32'h0);
    wr(off_event_flags, 32'h1);
    rdchk(off_event_flags, 32'hffff_ffff, 32'h6, "overflow clear");
    wr(off_irq_enable_clear, 32'h6);
    tick(2);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(off_event_flags, 32'h6);
    ce <= 1'b0;
    cnte <= 1;
    tick(1);
    cnte <= 0;
    ce <= 1'b1;
    rdchk(off_event_flags, 32'hffff_ffff, 32'h0, "frozen by clock enable");
    wr(off_control, 32'h1);
    idx <= 1; dbg <= 1;
    tick(1);
    idx <= 0; dbg <= 0;
    rdchk(off_event_flags, 32'hffff_ffff, 32'hc00, "update and debug");
    wr(off_event_flags, 32'hc00);
    rdchk(off_event_flags, 32'hffff_ffff, 32'h0, "all clear");
    $display("test events done");
  endtask
  task automatic cap(input logic [5:0] c, input logic [31:0] v);
    mc <= c; capv <= v;
    tick(1);
    mc <= 6'h0;
    tick(2);
  endtask
  // capture channel 1, overrun error, compare channel 0 buffer
  task automatic t_channel();
    wr(off_control, 32'h0000_0200);
    cap(6'h02, 32'h11);
    rdchk(off_unit_status, 32'h0002_0000, 32'h0002_0000, "capture buffer valid");
    cap(6'h02, 32'h22);
    rdchk(off_event_flags, 32'hffff_ffff, 32'h0002_0008, "overrun");
    rdchk(off_channel_value0 + 8'h4, 32'hffff_ffff, 32'h11, "kept value");
    rdchk(off_event_flags, 32'hffff_ffff, 32'h8, "read clears flag");
    rdchk(off_unit_status, 32'h0002_0000, 32'h0, "read clears valid");
    wr(off_event_flags, 32'h8);
    cap(6'h01, 32'h33);
    bw <= 6'h01;
    tick(1);
    bw <= 6'h0;
    rdchk(off_unit_status, 32'h0001_0000, 32'h0001_0000, "compare buffer valid");
    upd <= 1;
    tick(1);
    upd <= 0;
    rdchk(off_unit_status, 32'h0001_0000, 32'h0, "update clears");
    wr(off_event_flags, 32'h0);
    rdchk(off_event_flags, 32'hffff_ffff, 32'h0001_0000, "zero write");
    wr(off_event_flags, 32'h0001_0000);
    rdchk(off_event_flags, 32'hffff_ffff, 32'h0, "channel clear");
    $display("test channel done");
  endtask
  // each fault pin: flag, state, input bit, guarded clear
  task automatic t_faults();
    logic [31:0] b;
    int r;
    wr(off_control, 32'h0001_0000);
    for (int i = 0; i < 4; i++) begin
      b = 32'h1 << (12 + i);
      pin[i] <= 1'b1;
      tick(6);
      rdchk(off_event_flags, b, b, "fault flag");
      rdchk(off_unit_status, b | (b >> 4), b | (b >> 4), "state and input");
      wr(off_unit_status, b);
      rdchk(off_unit_status, b, b, "clear while high");
      pin[i] <= 1'b0;
      tick(4);
      bus(off_unit_status, 1'b1, b, 3'h0);
      rdchk(off_unit_status, b | (b >> 4), b, "narrow write");
      r = rel_cnt;
      if (i == 0) begin
        ra <= 1;
        tick(1);
        ra <= 0;
        tick(2);
      end else wr(off_unit_status, b);
      rdchk(off_unit_status, b, 32'h0, "state cleared");
      chk(rel_cnt - r, (i == 1) ? 1 : 0, "release pulse");
      wr(off_event_flags, b);
      rdchk(off_event_flags, b, 32'h0, "fault flag clear");
    end
    $display("test faults done");
  endtask
  initial begin
    tick(4);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_enable();
    t_events();
    t_channel();
    t_faults();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
